// File: design/sat_alu.sv
// lane-wise saturating alu slice with flag-only tests, behind AXI4-Lite
// assumes one clock, synchronous active-low reset, single-beat lite master
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sat_alu (
	// clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// write address channel
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [sat_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic [2:0]                   awprot,
	// write data channel
	input  wire logic                         wvalid,
	output logic                              wready,
	input  wire logic [sat_pkg::DATA_W-1:0]   wdata,
	input  wire logic [sat_pkg::STRB_W-1:0]   wstrb,
	// write response channel
	output logic                              bvalid,
	input  wire logic                         bready,
	output logic [1:0]                        bresp,
	// read address channel
	input  wire logic                         arvalid,
	output logic                              arready,
	input  wire logic [sat_pkg::ADDR_W-1:0]   araddr,
	input  wire logic [2:0]                   arprot,
	// read data channel
	output logic                              rvalid,
	input  wire logic                         rready,
	output logic [sat_pkg::DATA_W-1:0]        rdata,
	output logic [1:0]                        rresp
);
	// write and read channel holding state
	logic                          aw_held_q;
	logic [sat_pkg::ADDR_W-1:0]    aw_addr_q;
	logic                          w_held_q;
	logic [sat_pkg::DATA_W-1:0]    w_data_q;
	logic [sat_pkg::STRB_W-1:0]    w_strb_q;
	logic                          bvalid_q;
	logic [1:0]                    bresp_q;
	logic                          rvalid_q;
	logic [sat_pkg::DATA_W-1:0]    rdata_q;
	logic [1:0]                    rresp_q;

	// software visible registers and the execute pulse
	logic [sat_pkg::DATA_W-1:0]    opa_q;
	logic [sat_pkg::DATA_W-1:0]    opb_q;
	logic [sat_pkg::DATA_W-1:0]    pc_q;
	logic [sat_pkg::IMM_W-1:0]     imm_q;
	logic [sat_pkg::DATA_W-1:0]    ctrl_q;
	logic [sat_pkg::DATA_W-1:0]    result_q;
	logic [sat_pkg::FLAGS_W-1:0]   flags_q;
	logic                          exec_q;

	// decode helpers
	logic                          wr_fire;
	logic [7:0]                    wr_off;
	logic [7:0]                    rd_off;
	logic                          wr_hit;
	logic                          rd_hit;
	logic [sat_pkg::DATA_W-1:0]    rd_word;
	sat_pkg::sat_op_e              op;
	logic                          shift_used;
	logic                          shift_carry;

	// datapath
	logic [sat_pkg::DATA_W-1:0]    test_val;
	logic                          is_test;
	logic [sat_pkg::DATA_W-1:0]    imm_ext;
	logic [sat_pkg::DATA_W-1:0]    pc_sum;
	logic [sat_pkg::DATA_W-1:0]    alu_res;
	logic                          alu_wr;

	sat_lane_if byte_lif ();
	sat_lane_if half_lif ();

	// lane units
	assign byte_lif.opa = opa_q;
	assign byte_lif.opb = opb_q;
	assign half_lif.opa = opa_q;
	assign half_lif.opb = opb_q;

	sat_lane_unit #(.LANE_W(sat_pkg::BYTE_W)) u_byte (
		.lif (byte_lif.lane)
	);

	sat_lane_unit #(.LANE_W(sat_pkg::HALF_W)) u_half (
		.lif (half_lif.lane)
	);

	// byte-lane write merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
					      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// write channel: address and data taken in either order
	assign awready = !aw_held_q && !bvalid_q;
	assign wready  = !w_held_q && !bvalid_q;
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign wr_off  = aw_addr_q;
	assign wr_hit  = (wr_off == sat_pkg::OFF_OPA) || (wr_off == sat_pkg::OFF_OPB)
		      || (wr_off == sat_pkg::OFF_PC) || (wr_off == sat_pkg::OFF_IMM)
		      || (wr_off == sat_pkg::OFF_CTRL) || (wr_off == sat_pkg::OFF_RESULT)
		      || (wr_off == sat_pkg::OFF_FLAGS);
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= sat_pkg::RST_WORD;
			w_strb_q <= '0;
		end else if (wvalid && wready) begin
			w_held_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= sat_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? sat_pkg::RESP_OKAY : sat_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// operand, pc, offset and control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opa_q  <= sat_pkg::RST_WORD;
			opb_q  <= sat_pkg::RST_WORD;
			pc_q   <= sat_pkg::RST_WORD;
			imm_q  <= '0;
			ctrl_q <= sat_pkg::RST_WORD;
		end else if (wr_fire) begin
			if (wr_off == sat_pkg::OFF_OPA) begin
				opa_q <= merge(opa_q, w_data_q, w_strb_q);
			end
			if (wr_off == sat_pkg::OFF_OPB) begin
				opb_q <= merge(opb_q, w_data_q, w_strb_q);
			end
			if (wr_off == sat_pkg::OFF_PC) begin
				pc_q <= merge(pc_q, w_data_q, w_strb_q);
			end
			if (wr_off == sat_pkg::OFF_IMM) begin
				imm_q <= sat_pkg::IMM_W'(merge({{(32-sat_pkg::IMM_W){1'b0}}, imm_q}, w_data_q, w_strb_q));
			end
			if (wr_off == sat_pkg::OFF_CTRL) begin
				ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
			end
		end
	end

	// a control write launches one operation on the next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exec_q <= 1'b0;
		end else begin
			exec_q <= wr_fire && (wr_off == sat_pkg::OFF_CTRL);
		end
	end

	assign op          = sat_pkg::sat_op_e'(ctrl_q[sat_pkg::CTRL_OP_LSB +: sat_pkg::CTRL_OP_W]);
	assign shift_used  = ctrl_q[sat_pkg::CTRL_SHU];
	assign shift_carry = ctrl_q[sat_pkg::CTRL_SHC];

	// test value and pc-relative sum
	assign is_test  = (op == sat_pkg::SAT_OP_AND_TEST) || (op == sat_pkg::SAT_OP_XOR_TEST);
	assign test_val = (op == sat_pkg::SAT_OP_AND_TEST) ? (opa_q & opb_q) : (opa_q ^ opb_q);
	assign imm_ext  = {{(32-sat_pkg::IMM_W){imm_q[sat_pkg::IMM_W-1]}}, imm_q};
	assign pc_sum   = pc_q + imm_ext;

	// result select
	always_comb begin
		alu_res = result_q;
		alu_wr  = 1'b1;
		unique case (op)
			sat_pkg::SAT_OP_HW_ADD:  alu_res = half_lif.sum_wrap;
			sat_pkg::SAT_OP_BY_ADD:  alu_res = byte_lif.sum_wrap;
			sat_pkg::SAT_OP_HW_QADD: alu_res = half_lif.sum_sat;
			sat_pkg::SAT_OP_BY_QADD: alu_res = byte_lif.sum_sat;
			sat_pkg::SAT_OP_HW_QSUB: alu_res = half_lif.diff_sat;
			sat_pkg::SAT_OP_BY_QSUB: alu_res = byte_lif.diff_sat;
			sat_pkg::SAT_OP_PC_REL:  alu_res = pc_sum;
			default:                 alu_wr  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= sat_pkg::RST_WORD;
		end else if (exec_q && alu_wr) begin
			result_q <= alu_res;
		end
	end

	// flags: tests update n, z and maybe c; execution beats a software write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= sat_pkg::RST_FLAGS;
		end else if (exec_q && is_test) begin
			flags_q[sat_pkg::FLAG_N] <= test_val[sat_pkg::DATA_W-1];
			flags_q[sat_pkg::FLAG_Z] <= (test_val == '0);
			if (shift_used) begin
				flags_q[sat_pkg::FLAG_C] <= shift_carry;
			end
		end else if (wr_fire && (wr_off == sat_pkg::OFF_FLAGS) && w_strb_q[0]) begin
			flags_q <= w_data_q[sat_pkg::FLAGS_W-1:0];
		end
	end

	// read channel
	assign rd_off = araddr;
	assign rd_hit = (rd_off == sat_pkg::OFF_OPA) || (rd_off == sat_pkg::OFF_OPB)
		      || (rd_off == sat_pkg::OFF_PC) || (rd_off == sat_pkg::OFF_IMM)
		      || (rd_off == sat_pkg::OFF_CTRL) || (rd_off == sat_pkg::OFF_RESULT)
		      || (rd_off == sat_pkg::OFF_FLAGS);

	always_comb begin
		rd_word = sat_pkg::RST_WORD;
		unique case (rd_off)
			sat_pkg::OFF_OPA:    rd_word = opa_q;
			sat_pkg::OFF_OPB:    rd_word = opb_q;
			sat_pkg::OFF_PC:     rd_word = pc_q;
			sat_pkg::OFF_IMM:    rd_word = {{(32-sat_pkg::IMM_W){1'b0}}, imm_q};
			sat_pkg::OFF_CTRL:   rd_word = ctrl_q;
			sat_pkg::OFF_RESULT: rd_word = result_q;
			sat_pkg::OFF_FLAGS:  rd_word = {{(32-sat_pkg::FLAGS_W){1'b0}}, flags_q};
			default:             rd_word = sat_pkg::RST_WORD;
		endcase
	end

	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= sat_pkg::RST_WORD;
			rresp_q  <= sat_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? sat_pkg::RESP_OKAY : sat_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence exec_op(sat_pkg::sat_op_e o);
		exec_q && (op == o);
	endsequence

	sequence exec_test;
		exec_q && is_test;
	endsequence

	test_and_z_a: assert property (exec_op(sat_pkg::SAT_OP_AND_TEST) |=>
		flags_q[sat_pkg::FLAG_Z] == (($past(opa_q) & $past(opb_q)) == '0))
		else $error("and-test zero flag wrong");

	test_no_write_a: assert property (exec_test |=> $stable(result_q))
		else $error("test op changed result");

	xor_sign_a: assert property (exec_op(sat_pkg::SAT_OP_XOR_TEST) |=>
		flags_q[sat_pkg::FLAG_N] == ($past(opa_q[31]) ^ $past(opb_q[31])))
		else $error("xor-test negative flag wrong");

	xor_zero_a: assert property (exec_op(sat_pkg::SAT_OP_XOR_TEST) |=>
		flags_q[sat_pkg::FLAG_Z] == ($past(opa_q) == $past(opb_q)))
		else $error("xor-test zero flag wrong");

	test_carry_a: assert property (exec_test ##0 !shift_used |=>
		flags_q[sat_pkg::FLAG_C] == $past(flags_q[sat_pkg::FLAG_C]))
		else $error("carry changed without shift");

	test_ovf_a: assert property (exec_test |=> $stable(flags_q[sat_pkg::FLAG_V]))
		else $error("test op changed overflow");

	half_add_a: assert property (exec_op(sat_pkg::SAT_OP_HW_ADD) |=>
		result_q[31:16] == 16'($past(opa_q[31:16]) + $past(opb_q[31:16])))
		else $error("halfword add upper lane wrong");

	byte_add_a: assert property (exec_op(sat_pkg::SAT_OP_BY_ADD) |=>
		result_q[15:8] == 8'($past(opa_q[15:8]) + $past(opb_q[15:8])))
		else $error("byte add lane one wrong");

	half_qadd_a: assert property (exec_op(sat_pkg::SAT_OP_HW_QADD) ##0
		(({1'b0, opa_q[15:0]} + {1'b0, opb_q[15:0]}) > 17'h0FFFF) |=>
		result_q[15:0] == 16'hFFFF)
		else $error("halfword saturating add did not clamp");

	byte_qadd_a: assert property (exec_op(sat_pkg::SAT_OP_BY_QADD) |=>
		result_q[31:24] == ((9'($past(opa_q[31:24])) + 9'($past(opb_q[31:24]))) > 9'h0FF
			? 8'hFF : 8'($past(opa_q[31:24]) + $past(opb_q[31:24]))))
		else $error("byte saturating add lane wrong");

	half_qsub_a: assert property (exec_op(sat_pkg::SAT_OP_HW_QSUB) ##0
		(opb_q[31:16] > opa_q[31:16]) |=> result_q[31:16] == 16'h0000)
		else $error("halfword saturating subtract did not clamp");

	byte_qsub_a: assert property (exec_op(sat_pkg::SAT_OP_BY_QSUB) |=>
		result_q[7:0] == (($past(opb_q[7:0]) > $past(opa_q[7:0]))
			? 8'h00 : 8'($past(opa_q[7:0]) - $past(opb_q[7:0]))))
		else $error("byte saturating subtract lane wrong");

	pc_rel_a: assert property (exec_op(sat_pkg::SAT_OP_PC_REL) |=>
		result_q == $past(pc_q) + {{(32-sat_pkg::IMM_W){$past(imm_q[sat_pkg::IMM_W-1])}}, $past(imm_q)})
		else $error("pc-relative sum wrong");

	pc_flags_a: assert property (exec_op(sat_pkg::SAT_OP_PC_REL) ##0 !wr_fire |=>
		$stable(flags_q))
		else $error("pc-relative changed flags");

	lane_iso_a: assert property (exec_op(sat_pkg::SAT_OP_BY_QSUB) |=>
		result_q[15:8] == (($past(opb_q[15:8]) > $past(opa_q[15:8]))
			? 8'h00 : 8'($past(opa_q[15:8]) - $past(opb_q[15:8]))))
		else $error("borrow crossed a byte lane");

	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");

endmodule : sat_alu
`default_nettype wire

// File: design/sat_pkg.sv
// constants for the lane-wise saturating alu slice
// assumes a 32-bit AXI4-Lite register bus and one clock domain
package sat_pkg;

	// bus geometry
	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 8;
	localparam int          STRB_W      = DATA_W / 8;

	// register byte offsets
	localparam logic [7:0]  OFF_OPA     = 8'h00;
	localparam logic [7:0]  OFF_OPB     = 8'h04;
	localparam logic [7:0]  OFF_PC      = 8'h08;
	localparam logic [7:0]  OFF_IMM     = 8'h0C;
	localparam logic [7:0]  OFF_CTRL    = 8'h10;
	localparam logic [7:0]  OFF_RESULT  = 8'h14;
	localparam logic [7:0]  OFF_FLAGS   = 8'h18;

	// bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// control register fields
	localparam int          CTRL_OP_LSB = 0;
	localparam int          CTRL_OP_W   = 4;
	localparam int          CTRL_SHU    = 8;
	localparam int          CTRL_SHC    = 9;

	// flags register fields
	localparam int          FLAG_N      = 3;
	localparam int          FLAG_Z      = 2;
	localparam int          FLAG_C      = 1;
	localparam int          FLAG_V      = 0;
	localparam int          FLAGS_W     = 4;

	// pc-relative offset field
	localparam int          IMM_W       = 13;
	localparam int          IMM_MAX     = 4095;

	// lane widths
	localparam int          BYTE_W      = 8;
	localparam int          HALF_W      = 16;

	// reset values
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [3:0]  RST_FLAGS   = 4'h0;

	// operation codes
	typedef enum logic [3:0] {
		SAT_OP_NONE     = 4'h0,
		SAT_OP_AND_TEST = 4'h1,
		SAT_OP_XOR_TEST = 4'h2,
		SAT_OP_HW_ADD   = 4'h3,
		SAT_OP_BY_ADD   = 4'h4,
		SAT_OP_HW_QADD  = 4'h5,
		SAT_OP_BY_QADD  = 4'h6,
		SAT_OP_HW_QSUB  = 4'h7,
		SAT_OP_BY_QSUB  = 4'h8,
		SAT_OP_PC_REL   = 4'h9
	} sat_op_e;

endpackage : sat_pkg

// File: design/sat_lane_if.sv
// operand and lane result bundle between the alu and a lane unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface sat_lane_if;
	logic [sat_pkg::DATA_W-1:0] opa;
	logic [sat_pkg::DATA_W-1:0] opb;
	logic [sat_pkg::DATA_W-1:0] sum_wrap;
	logic [sat_pkg::DATA_W-1:0] sum_sat;
	logic [sat_pkg::DATA_W-1:0] diff_sat;

	modport alu  (output opa, output opb, input sum_wrap, input sum_sat, input diff_sat);
	modport lane (input opa, input opb, output sum_wrap, output sum_sat, output diff_sat);
endinterface : sat_lane_if
`default_nettype wire

// File: design/sat_lane_unit.sv
// lane-wise wrap add, saturating add and saturating subtract
// assumes operands arrive on a sat_lane_if, purely combinational
`timescale 1ns/1ps
`default_nettype none
module sat_lane_unit #(
	parameter int LANE_W = 8
) (
	// operands and results
	sat_lane_if.lane lif
);
	localparam int NLANES = sat_pkg::DATA_W / LANE_W;

	// one adder and one subtractor per lane, no carry between lanes
	for (genvar i = 0; i < NLANES; i++) begin : g_lane
		logic [LANE_W:0] sum;
		logic [LANE_W:0] dif;
		assign sum = {1'b0, lif.opa[i*LANE_W +: LANE_W]} + {1'b0, lif.opb[i*LANE_W +: LANE_W]};
		assign dif = {1'b0, lif.opa[i*LANE_W +: LANE_W]} - {1'b0, lif.opb[i*LANE_W +: LANE_W]};
		assign lif.sum_wrap[i*LANE_W +: LANE_W] = sum[LANE_W-1:0];
		assign lif.sum_sat[i*LANE_W +: LANE_W]  = sum[LANE_W] ? {LANE_W{1'b1}} : sum[LANE_W-1:0];
		assign lif.diff_sat[i*LANE_W +: LANE_W] = dif[LANE_W] ? {LANE_W{1'b0}} : dif[LANE_W-1:0];
	end
endmodule : sat_lane_unit
`default_nettype wire

// File: verif/sat_host.sv
// AXI4-Lite master model for the decoder and register file side
// assumes one clock; drives after rising edges, waits without limit
`timescale 1ns/1ps
`default_nettype none
module sat_host (
	// clock
	input  wire logic        aclk,
	// write channels
	output logic             awvalid,
	input  wire logic        awready,
	output logic [7:0]       awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic [1:0]  bresp,
	// read channels
	output logic             arvalid,
	input  wire logic        arready,
	output logic [7:0]       araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	initial begin
		awvalid = 1'b0;
		awaddr  = 8'h00;
		wvalid  = 1'b0;
		wdata   = 32'h0;
		wstrb   = 4'h0;
		bready  = 1'b0;
		arvalid = 1'b0;
		araddr  = 8'h00;
		rready  = 1'b0;
	end
	// one write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			// bready waits for bvalid, so the held response is exercised
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end else if (bvalid) begin
				bready <= 1'b1;
			end
		end
	endtask : wr
	// one read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd
endmodule : sat_host
`default_nettype wire

// File: verif/simd_saturating_alu_test_bench.sv
// self-checking bench for the lane-wise saturating alu slice
// assumes sat_host as bus master, 40 MHz clock, reset held 6 cycles
`timescale 1ns/1ps
`default_nettype none
module simd_saturating_alu_test_bench;
	logic        aclk;
	logic        aresetn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, last;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          n_fail  = 0;
	int          checked = 0;
	int          cyc     = 0;

	sat_alu DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	sat_host host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		host.wr(a, d, 4'hF, r);
		check("bresp", 32'(r), 32'(er));
	endtask : wrc
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		host.rd(a, d, r);
		check(nm, d, e);
		check("rresp", 32'(r), 32'(er));
	endtask : rdc
	function automatic logic [31:0] ctl(input logic [3:0] op, input logic shu, input logic shc);
		return {22'h0, shc, shu, 4'h0, op};
	endfunction : ctl
	task automatic run(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		wrc(sat_pkg::OFF_OPA, a, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_OPB, b, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_CTRL, c | 32'(op), sat_pkg::RESP_OKAY);
	endtask : run
	// lane-wise reference, each lane on its own
	function automatic logic [31:0] lane(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		logic [31:0] y;
		int          w, m, p, q, x;
		y = 32'h0;
		w = (op == 4'h3 || op == 4'h5 || op == 4'h7) ? 16 : 8;
		m = (1 << w) - 1;
		for (int i = 0; i < 32; i += w) begin
			p = int'((a >> i) & 32'(m));
			q = int'((b >> i) & 32'(m));
			if (op == 4'h3 || op == 4'h4) x = (p + q) & m;
			else if (op == 4'h5 || op == 4'h6) x = (p + q > m) ? m : p + q;
			else x = (p < q) ? 0 : p - q;
			y = y | (32'(x) << i);
		end
		return y;
	endfunction : lane

	task automatic t_reset;
		rdc("result", sat_pkg::OFF_RESULT, 32'h0, sat_pkg::RESP_OKAY);
		rdc("flags", sat_pkg::OFF_FLAGS, 32'h0, sat_pkg::RESP_OKAY);
		rdc("unmapped", 8'h1C, 32'h0, sat_pkg::RESP_SLVERR);
		wrc(8'h1C, 32'h1234_5678, sat_pkg::RESP_SLVERR);
		$display("test reset done");
	endtask : t_reset

	task automatic t_lanes;
		logic [31:0] av [3] = '{32'hFFF0_80FF, 32'h0102_0304, 32'h8000_7FFF};
		logic [31:0] bv [3] = '{32'h0020_8001, 32'h0203_0405, 32'h8000_0001};
		for (int op = 3; op <= 8; op++) begin
			for (int k = 0; k < 3; k++) begin
				run(4'(op), av[k], bv[k], 32'h0);
				last = lane(4'(op), av[k], bv[k]);
				rdc("lane result", sat_pkg::OFF_RESULT, last, sat_pkg::RESP_OKAY);
			end
		end
		$display("test lanes done");
	endtask : t_lanes

	task automatic t_tests;
		wrc(sat_pkg::OFF_FLAGS, 32'h1, sat_pkg::RESP_OKAY);
		run(sat_pkg::SAT_OP_AND_TEST, 32'hF0F0_0000, 32'h0F0F_FFFF, ctl(4'h0, 1'b0, 1'b1));
		rdc("and zero", sat_pkg::OFF_FLAGS, 32'h5, sat_pkg::RESP_OKAY);
		rdc("test result", sat_pkg::OFF_RESULT, last, sat_pkg::RESP_OKAY);
		run(sat_pkg::SAT_OP_XOR_TEST, 32'h8000_0001, 32'h0000_0001, ctl(4'h0, 1'b1, 1'b1));
		rdc("xor sign", sat_pkg::OFF_FLAGS, 32'hB, sat_pkg::RESP_OKAY);
		run(sat_pkg::SAT_OP_AND_TEST, 32'hFFFF_FFFF, 32'h8000_0000, ctl(4'h0, 1'b1, 1'b0));
		rdc("and neg", sat_pkg::OFF_FLAGS, 32'h9, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_FLAGS, 32'h2, sat_pkg::RESP_OKAY);
		run(sat_pkg::SAT_OP_XOR_TEST, 32'h7FFF_0001, 32'h7FFF_0001, ctl(4'h0, 1'b0, 1'b0));
		rdc("xor equal", sat_pkg::OFF_FLAGS, 32'h6, sat_pkg::RESP_OKAY);
		rdc("test result", sat_pkg::OFF_RESULT, last, sat_pkg::RESP_OKAY);
		$display("test flags done");
	endtask : t_tests

	task automatic t_pcrel;
		wrc(sat_pkg::OFF_FLAGS, 32'hA, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_PC, 32'h0000_1000, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_IMM, 32'h0000_1001, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_CTRL, 32'(sat_pkg::SAT_OP_PC_REL), sat_pkg::RESP_OKAY);
		rdc("pc minus", sat_pkg::OFF_RESULT, 32'h0000_0001, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_IMM, 32'h0000_0FFF, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_CTRL, 32'(sat_pkg::SAT_OP_PC_REL), sat_pkg::RESP_OKAY);
		rdc("pc plus", sat_pkg::OFF_RESULT, 32'h0000_1FFF, sat_pkg::RESP_OKAY);
		rdc("pc flags", sat_pkg::OFF_FLAGS, 32'hA, sat_pkg::RESP_OKAY);
		$display("test pc-relative done");
	endtask : t_pcrel

	task automatic t_ro;
		logic [1:0] r;
		wrc(sat_pkg::OFF_RESULT, 32'hDEAD_BEEF, sat_pkg::RESP_OKAY);
		rdc("result ro", sat_pkg::OFF_RESULT, 32'h0000_1FFF, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_OPA, 32'hFFFF_FFFF, sat_pkg::RESP_OKAY);
		host.wr(sat_pkg::OFF_OPA, 32'h0, 4'h3, r);
		check("bresp", 32'(r), 32'(sat_pkg::RESP_OKAY));
		rdc("strobe", sat_pkg::OFF_OPA, 32'hFFFF_0000, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_CTRL, 32'h0000_000F, sat_pkg::RESP_OKAY);
		rdc("idle op", sat_pkg::OFF_RESULT, 32'h0000_1FFF, sat_pkg::RESP_OKAY);
		wrc(sat_pkg::OFF_CTRL, 32'h0000_0000, sat_pkg::RESP_OKAY);
		rdc("no op", sat_pkg::OFF_RESULT, 32'h0000_1FFF, sat_pkg::RESP_OKAY);
		rdc("idle flags", sat_pkg::OFF_FLAGS, 32'hA, sat_pkg::RESP_OKAY);
		$display("test access done");
	endtask : t_ro

	task automatic close_out;
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out

	initial begin
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_lanes();
		t_tests();
		t_pcrel();
		t_ro();
		close_out();
	end
endmodule : simd_saturating_alu_test_bench
`default_nettype wire
